// file: inc/ircps_pkg.sv
// constants for the interrupt, reset-cause, program counter and return stack block
package ircps_pkg;
   // file addresses of the registers
   localparam logic [7:0] IRQ_CONTROL_ADDR0 = 8'h0B;
   localparam logic [7:0] IRQ_CONTROL_ADDR1 = 8'h8B;
   localparam logic [7:0] PERIPH_FLAG_ADDR = 8'h0C;
   localparam logic [7:0] PERIPH_ENABLE_ADDR = 8'h8C;
   localparam logic [7:0] RESET_CAUSE_ADDR = 8'h8E;
   localparam logic [7:0] PC_LOW_BYTE_ADDR0 = 8'h02;
   localparam logic [7:0] PC_LOW_BYTE_ADDR1 = 8'h82;
   localparam logic [7:0] PC_HIGH_HOLDING_ADDR0 = 8'h0A;
   localparam logic [7:0] PC_HIGH_HOLDING_ADDR1 = 8'h8A;

   // irq_control field positions
   localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
   localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
   localparam int TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
   localparam int EXT_PIN_IRQ_ENABLE_BIT = 4;
   localparam int PORT_CHANGE_IRQ_ENABLE_BIT = 3;
   localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
   localparam int EXT_PIN_FLAG_BIT = 1;
   localparam int PORT_CHANGE_FLAG_BIT = 0;

   // peripheral enable and flag share one position
   localparam int COMPARATOR_BIT = 6;

   // reset_cause field positions
   localparam int POWER_ON_STATUS_BIT = 1;
   localparam int BROWNOUT_FLAG_BIT = 0;

   // reset values
   localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
   localparam logic PERIPH_RESET = 1'b0;
   localparam logic [4:0] PC_HIGH_HOLDING_RESET = 5'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // program counter and stack geometry
   localparam int PC_WIDTH = 13;
   localparam int HOLDING_WIDTH = 5;
   localparam int JUMP_WIDTH = 11;
   localparam int STACK_DEPTH = 8;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;

   // watched port pins
   localparam int PORT_CHANGE_WIDTH = 4;
endpackage : ircps_pkg

// file: src/ircps_core.sv
// interrupt enables and flags, reset cause, program counter and return stack
`timescale 1ns/100ps
`default_nettype none
module ircps_core #(
   parameter int STACK_DEPTH = ircps_pkg::STACK_DEPTH,
   parameter logic [12:0] VECTOR = ircps_pkg::IRQ_VECTOR
) (
   input wire logic clk,
   input wire logic sys_rst,
   // reset controller tells which kind of reset is in progress
   input wire logic power_on_reset_cause,
   input wire logic brownout_reset_cause,
   input wire logic brownout_config_enable,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // interrupt sources, one-cycle pulses on clk
   input wire logic timer_overflow_event,
   input wire logic ext_pin_event,
   input wire logic comparator_change_event,
   // port pins 7:4 and their direction bits (1 = input)
   input wire logic [ircps_pkg::PORT_CHANGE_WIDTH-1:0] port_pins,
   input wire logic [ircps_pkg::PORT_CHANGE_WIDTH-1:0] port_is_input,
   input wire logic port_access,
   // sequencing from the instruction decoder
   input wire logic pc_advance,
   input wire logic jump_op,
   input wire logic call_op,
   input wire logic [ircps_pkg::JUMP_WIDTH-1:0] jump_target,
   input wire logic return_op,
   input wire logic irq_take,
   output logic [ircps_pkg::PC_WIDTH-1:0] pc,
   output logic irq_request
);
   import ircps_pkg::*;

   if (STACK_DEPTH != 8) begin : g_depth_check
      $error("ircps_core return stack must be eight deep");
   end

   typedef struct packed {
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic timer_overflow_irq_enable;
      logic ext_pin_irq_enable;
      logic port_change_irq_enable;
      logic timer_overflow_flag;
      logic ext_pin_flag;
      logic port_change_flag;
      logic comparator_irq_enable;
      logic comparator_change_flag;
      logic power_on_status;
      logic brownout_flag;
      logic [HOLDING_WIDTH-1:0] pc_high_holding;
      logic [PC_WIDTH-1:0] pc;
      logic [PORT_CHANGE_WIDTH-1:0] pin_meta;
      logic [PORT_CHANGE_WIDTH-1:0] pin_sync;
      logic [PORT_CHANGE_WIDTH-1:0] port_latch;
      logic [7:0] rdata;
      logic irq_request;
   } ircps_core_state_t;

   ircps_core_state_t state;
   ircps_core_state_t next_state;
   logic [PC_WIDTH-1:0] stack_top;
   logic stack_push;
   logic stack_pop;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] x0, input logic [7:0] x1);
      addr_hit = (a == x0) || (a == x1);
   endfunction : addr_hit

   function automatic logic [7:0] irq_control_value(input ircps_core_state_t s);
      logic [7:0] v;
      v = 8'h00;
      v[GLOBAL_IRQ_ENABLE_BIT] = s.global_irq_enable;
      v[PERIPHERAL_IRQ_ENABLE_BIT] = s.peripheral_irq_enable;
      v[TIMER_OVERFLOW_IRQ_ENABLE_BIT] = s.timer_overflow_irq_enable;
      v[EXT_PIN_IRQ_ENABLE_BIT] = s.ext_pin_irq_enable;
      v[PORT_CHANGE_IRQ_ENABLE_BIT] = s.port_change_irq_enable;
      v[TIMER_OVERFLOW_FLAG_BIT] = s.timer_overflow_flag;
      v[EXT_PIN_FLAG_BIT] = s.ext_pin_flag;
      v[PORT_CHANGE_FLAG_BIT] = s.port_change_flag;
      irq_control_value = v;
   endfunction : irq_control_value

   logic wr_irq_control;
   logic wr_periph_flag;
   logic wr_periph_enable;
   logic wr_reset_cause;
   logic wr_pc_low;
   logic wr_holding;
   logic [PORT_CHANGE_WIDTH-1:0] mismatch;
   logic port_change_event;

   always_comb begin
      wr_irq_control = reg_wr && addr_hit(reg_addr, IRQ_CONTROL_ADDR0, IRQ_CONTROL_ADDR1);
      wr_periph_flag = reg_wr && (reg_addr == PERIPH_FLAG_ADDR);
      wr_periph_enable = reg_wr && (reg_addr == PERIPH_ENABLE_ADDR);
      wr_reset_cause = reg_wr && (reg_addr == RESET_CAUSE_ADDR);
      wr_pc_low = reg_wr && addr_hit(reg_addr, PC_LOW_BYTE_ADDR0, PC_LOW_BYTE_ADDR1);
      wr_holding = reg_wr && addr_hit(reg_addr, PC_HIGH_HOLDING_ADDR0, PC_HIGH_HOLDING_ADDR1);
      // only input pins take part in the comparison
      mismatch = (state.pin_sync ^ state.port_latch) & port_is_input;
      port_change_event = |mismatch;
   end

   assign stack_push = !sys_rst && (irq_take || call_op);
   assign stack_pop = !sys_rst && !irq_take && !call_op && !jump_op && return_op;

   always_comb begin
      next_state = state;

      // two-stage synchroniser for the port pins
      next_state.pin_meta = port_pins;
      next_state.pin_sync = state.pin_meta;
      // a port access re-arms the comparison against the present pin values
      if (port_access) begin
         next_state.port_latch = state.pin_sync;
      end

      // software writes first; hardware sets below so a set in the clear cycle wins
      if (wr_irq_control) begin
         next_state.global_irq_enable = reg_wdata[GLOBAL_IRQ_ENABLE_BIT];
         next_state.peripheral_irq_enable = reg_wdata[PERIPHERAL_IRQ_ENABLE_BIT];
         next_state.timer_overflow_irq_enable = reg_wdata[TIMER_OVERFLOW_IRQ_ENABLE_BIT];
         next_state.ext_pin_irq_enable = reg_wdata[EXT_PIN_IRQ_ENABLE_BIT];
         next_state.port_change_irq_enable = reg_wdata[PORT_CHANGE_IRQ_ENABLE_BIT];
         next_state.timer_overflow_flag = reg_wdata[TIMER_OVERFLOW_FLAG_BIT];
         next_state.ext_pin_flag = reg_wdata[EXT_PIN_FLAG_BIT];
         next_state.port_change_flag = reg_wdata[PORT_CHANGE_FLAG_BIT];
      end
      if (wr_periph_enable) begin
         next_state.comparator_irq_enable = reg_wdata[COMPARATOR_BIT];
      end
      if (wr_periph_flag) begin
         next_state.comparator_change_flag = reg_wdata[COMPARATOR_BIT];
      end
      if (wr_reset_cause) begin
         next_state.power_on_status = reg_wdata[POWER_ON_STATUS_BIT];
         next_state.brownout_flag = reg_wdata[BROWNOUT_FLAG_BIT];
      end
      if (wr_holding) begin
         next_state.pc_high_holding = reg_wdata[HOLDING_WIDTH-1:0];
      end

      // flags set without looking at enables
      if (timer_overflow_event) begin
         next_state.timer_overflow_flag = 1'b1;
      end
      if (ext_pin_event) begin
         next_state.ext_pin_flag = 1'b1;
      end
      // a standing mismatch keeps setting the flag
      if (port_change_event) begin
         next_state.port_change_flag = 1'b1;
      end
      if (comparator_change_event) begin
         next_state.comparator_change_flag = 1'b1;
      end

      // program counter sources in falling priority
      // no stack action touches pc_high_holding
      if (irq_take) begin
         next_state.pc = VECTOR;
      end else if (call_op || jump_op) begin
         next_state.pc = {state.pc_high_holding[HOLDING_WIDTH-1:HOLDING_WIDTH-2], jump_target};
      end else if (return_op) begin
         next_state.pc = stack_top;
      end else if (wr_pc_low) begin
         // upper bits have no path of their own
         next_state.pc = {state.pc_high_holding, reg_wdata};
      end else if (pc_advance) begin
         // the increment carries through all 13 bits, past the low byte's wrap
         next_state.pc = state.pc + 1'b1;
      end

      next_state.irq_request = next_state.global_irq_enable && (
         (next_state.timer_overflow_flag && next_state.timer_overflow_irq_enable) ||
         (next_state.ext_pin_flag && next_state.ext_pin_irq_enable) ||
         (next_state.port_change_flag && next_state.port_change_irq_enable) ||
         (next_state.comparator_change_flag && next_state.comparator_irq_enable &&
          next_state.peripheral_irq_enable));

      // read data stand only in the cycle after the strobe
      next_state.rdata = READ_IDLE;
      if (reg_rd) begin
         if (addr_hit(reg_addr, IRQ_CONTROL_ADDR0, IRQ_CONTROL_ADDR1)) begin
            next_state.rdata = irq_control_value(state);
         end else if (reg_addr == PERIPH_ENABLE_ADDR) begin
            next_state.rdata[COMPARATOR_BIT] = state.comparator_irq_enable;
         end else if (reg_addr == PERIPH_FLAG_ADDR) begin
            next_state.rdata[COMPARATOR_BIT] = state.comparator_change_flag;
         end else if (reg_addr == RESET_CAUSE_ADDR) begin
            next_state.rdata[POWER_ON_STATUS_BIT] = state.power_on_status;
            next_state.rdata[BROWNOUT_FLAG_BIT] = state.brownout_flag;
         end else if (addr_hit(reg_addr, PC_LOW_BYTE_ADDR0, PC_LOW_BYTE_ADDR1)) begin
            next_state.rdata = state.pc[7:0];
         end else if (addr_hit(reg_addr, PC_HIGH_HOLDING_ADDR0, PC_HIGH_HOLDING_ADDR1)) begin
            next_state.rdata[HOLDING_WIDTH-1:0] = state.pc_high_holding;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state.pc <= PC_RESET;
         {state.global_irq_enable, state.peripheral_irq_enable, state.timer_overflow_irq_enable,
          state.ext_pin_irq_enable, state.port_change_irq_enable, state.timer_overflow_flag,
          state.ext_pin_flag, state.port_change_flag} <= IRQ_CONTROL_RESET;
         state.comparator_irq_enable <= PERIPH_RESET;
         state.comparator_change_flag <= PERIPH_RESET;
         state.pc_high_holding <= PC_HIGH_HOLDING_RESET;
         state.pin_meta <= '0;
         state.pin_sync <= '0;
         state.port_latch <= '0;
         state.rdata <= READ_IDLE;
         state.irq_request <= 1'b0;
         if (power_on_reset_cause) begin
            state.power_on_status <= 1'b0;
            // value after power-on carries no meaning; held at zero
            state.brownout_flag <= 1'b0;
         end else if (brownout_reset_cause && brownout_config_enable) begin
            state.brownout_flag <= 1'b0;
         end
      end else begin
         state <= next_state;
      end
   end

   ircps_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PC_WIDTH)
   ) u_stack (
      .clk(clk),
      .sys_rst(sys_rst),
      .push(stack_push),
      .pop(stack_pop),
      .push_data(state.pc),
      .top_data(stack_top)
   );

   assign pc = state.pc;
   assign reg_rdata = state.rdata;
   assign irq_request = state.irq_request;
endmodule : ircps_core
`default_nettype wire

// file: src/ircps_stack.sv
// circular return stack for the program counter
`timescale 1ns/100ps
`default_nettype none
module ircps_stack #(
   parameter int DEPTH = ircps_pkg::STACK_DEPTH,
   parameter int WIDTH = ircps_pkg::PC_WIDTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top_data
);
   import ircps_pkg::*;

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("ircps_stack depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] entry;
      logic [PTR_W-1:0] ptr;
   } ircps_stack_state_t;

   ircps_stack_state_t state;
   ircps_stack_state_t next_state;

   // ptr names the next free slot; one below it is the top
   always_comb begin
      next_state = state;
      if (push) begin
         // the pointer wraps so a ninth push overwrites the first entry
         next_state.entry[state.ptr] = push_data;
         next_state.ptr = state.ptr + 1'b1;
      end else if (pop) begin
         // underflow wraps silently; nothing flags it
         next_state.ptr = state.ptr - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign top_data = state.entry[state.ptr - 1'b1];
endmodule : ircps_stack
`default_nettype wire

// file: verif/ircps_core_asserts.sv
// port-level checks of the core's program counter and register reads
`timescale 1ns/100ps
`default_nettype none
module ircps_core_asserts #(
   parameter logic [12:0] VECTOR = ircps_pkg::IRQ_VECTOR
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic pc_advance,
   input wire logic jump_op,
   input wire logic call_op,
   input wire logic [ircps_pkg::JUMP_WIDTH-1:0] jump_target,
   input wire logic return_op,
   input wire logic irq_take,
   input wire logic [ircps_pkg::PC_WIDTH-1:0] pc,
   input wire logic irq_request
);
   import ircps_pkg::*;
   logic low_wr;
   logic pc_cause;
   logic branch;
   assign low_wr = reg_wr & (reg_addr == PC_LOW_BYTE_ADDR0 || reg_addr == PC_LOW_BYTE_ADDR1);
   assign branch = irq_take | call_op | jump_op;
   assign pc_cause = branch | return_op | pc_advance | low_wr;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_pc_reset_zero: assert property ($fell(sys_rst) |-> pc == PC_RESET)
      else $error("pc not zero after reset");
   a_low_write_load: assert property (low_wr && !branch && !return_op |=> pc[7:0] == $past(reg_wdata))
      else $error("pc low byte not loaded by write");
   a_jump_target_low: assert property ((call_op || jump_op) && !irq_take |=> pc[10:0] == $past(jump_target))
      else $error("jump target not loaded");
   a_irq_vector_load: assert property (irq_take |=> pc == VECTOR)
      else $error("vector not loaded on irq take");
   a_call_return_pair: assert property ((call_op && !irq_take) ##1 (return_op && !branch) |=> pc == $past(pc, 2))
      else $error("return did not restore pushed pc");
   a_pc_stays_put: assert property (!$past(sys_rst) && !$past(pc_cause) |-> $stable(pc))
      else $error("pc changed without cause");
   a_advance_one_step: assert property (pc_advance && !branch && !return_op && !low_wr |=> pc == $past(pc) + 13'h0001)
      else $error("pc advance wrong");
   a_periph_unused_zero: assert property (!$past(sys_rst) && $past(reg_rd) && ($past(reg_addr) == PERIPH_FLAG_ADDR
      || $past(reg_addr) == PERIPH_ENABLE_ADDR) |-> (reg_rdata & 8'hBF) == 8'h00)
      else $error("unused peripheral bits not zero");
   c_irq_take: cover property (irq_take);
   c_irq_rise: cover property ($rose(irq_request));
   c_call_return: cover property (call_op ##1 return_op);
endmodule : ircps_core_asserts
bind ircps_core ircps_core_asserts #(.VECTOR(VECTOR)) i_asserts (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_advance(pc_advance),
   .jump_op(jump_op), .call_op(call_op), .jump_target(jump_target), .return_op(return_op), .irq_take(irq_take),
   .pc(pc), .irq_request(irq_request));
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the interrupt, reset-cause and program counter core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import ircps_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic po = 1'b1;
   logic bo = 1'b0;
   logic bcfg = 1'b1;
   logic [7:0] ra = 8'h00;
   logic [7:0] wd = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [2:0] evs = 3'h0;
   logic [3:0] pins = 4'h0;
   logic [3:0] pin_in = 4'h0;
   logic pacc = 1'b0;
   logic [4:0] ops = 5'h0;
   logic [10:0] tgt = 11'h000;
   wire logic [7:0] rdata;
   wire logic [12:0] pc;
   wire logic irq;
   int num_errors = 0;
   int n_compared = 0;
   logic [7:0] ic, pf, pe, rc, hold;
   int mpc;
   int sp;
   int stk [8];
   always #2 clk = ~clk;
   ircps_core i_dut (.clk(clk), .sys_rst(sys_rst), .power_on_reset_cause(po), .brownout_reset_cause(bo),
      .brownout_config_enable(bcfg), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
      .timer_overflow_event(evs[0]), .ext_pin_event(evs[1]), .comparator_change_event(evs[2]), .port_pins(pins),
      .port_is_input(pin_in), .port_access(pacc), .pc_advance(ops[0]), .jump_op(ops[1]), .call_op(ops[2]),
      .jump_target(tgt), .return_op(ops[3]), .irq_take(ops[4]), .pc(pc), .irq_request(irq));
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function automatic logic [7:0] mr(input logic [7:0] a);
      case (a)
         IRQ_CONTROL_ADDR0, IRQ_CONTROL_ADDR1: return ic;
         PERIPH_FLAG_ADDR: return pf;
         PERIPH_ENABLE_ADDR: return pe;
         RESET_CAUSE_ADDR: return rc;
         PC_LOW_BYTE_ADDR0, PC_LOW_BYTE_ADDR1: return mpc[7:0];
         PC_HIGH_HOLDING_ADDR0, PC_HIGH_HOLDING_ADDR1: return hold;
         default: return 8'h00;
      endcase
   endfunction : mr
   // comparator source also needs the peripheral enable
   function automatic logic irq_m();
      return ic[7] & ((|(ic[5:3] & ic[2:0])) | (ic[6] & pf[6] & pe[6]));
   endfunction : irq_m
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      case (a)
         IRQ_CONTROL_ADDR0, IRQ_CONTROL_ADDR1: ic = d;
         PERIPH_FLAG_ADDR: pf = d & 8'h40;
         PERIPH_ENABLE_ADDR: pe = d & 8'h40;
         RESET_CAUSE_ADDR: rc = d & 8'h03;
         PC_LOW_BYTE_ADDR0, PC_LOW_BYTE_ADDR1: mpc = {hold[4:0], d};
         PC_HIGH_HOLDING_ADDR0, PC_HIGH_HOLDING_ADDR1: hold = d & 8'h1F;
         default: ;
      endcase
      #1;
      chk("irq", 16'(irq), 16'(irq_m()));
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk("rdata", 16'(rdata), 16'(mr(a)));
      @(posedge clk);
      #1;
      chk("rdata_idle", 16'(rdata), 16'h0000);
   endtask : rd
   task automatic ev(input int k);
      @(posedge clk);
      evs[k] <= 1'b1;
      @(posedge clk);
      evs <= 3'h0;
      if (k == 0) ic[2] = 1'b1;
      else if (k == 1) ic[1] = 1'b1;
      else pf[6] = 1'b1;
      #1;
      chk("irq", 16'(irq), 16'(irq_m()));
   endtask : ev
   task automatic op(input int k, input logic [10:0] t);
      @(posedge clk);
      ops[k] <= 1'b1;
      tgt <= t;
      @(posedge clk);
      ops <= 5'h00;
      if (k == 2 || k == 4) begin
         stk[sp] = mpc;
         sp = (sp + 1) % 8;
      end
      if (k == 0) mpc = (mpc + 1) % 8192;
      else if (k == 3) begin
         sp = (sp + 7) % 8;
         mpc = stk[sp];
      end else if (k == 4) mpc = IRQ_VECTOR;
      else mpc = {hold[4:3], t};
      #1;
      chk("pc", 16'(pc), 16'(mpc));
   endtask : op
   task automatic rst(input logic p, input logic b, input logic e);
      @(posedge clk);
      sys_rst <= 1'b1;
      po <= p;
      bo <= b;
      bcfg <= e;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      po <= 1'b0;
      bo <= 1'b0;
      {ic, pf, pe, hold} = 32'h0;
      mpc = 0;
      sp = 0;
      if (p) rc = 8'h00;
      else if (b && e) rc[0] = 1'b0;
      #1;
      chk("pc", 16'(pc), 16'h0000);
   endtask : rst
   initial begin
      void'($urandom(32'h233F0DD5));
      rst(1'b1, 1'b0, 1'b1);
      rd(RESET_CAUSE_ADDR);
      wr(RESET_CAUSE_ADDR, 8'hFF);
      rst(1'b0, 1'b1, 1'b0);
      rd(RESET_CAUSE_ADDR);
      rst(1'b0, 1'b1, 1'b1);
      rd(RESET_CAUSE_ADDR);
      repeat (4) begin
         wr(IRQ_CONTROL_ADDR0, 8'($urandom));
         rd(IRQ_CONTROL_ADDR1);
         wr(IRQ_CONTROL_ADDR1, 8'($urandom));
         rd(IRQ_CONTROL_ADDR0);
      end
      wr(PERIPH_FLAG_ADDR, 8'hFF);
      wr(PERIPH_ENABLE_ADDR, 8'hFF);
      wr(8'h33, 8'h55);
      rd(8'h33);
      rd(PERIPH_FLAG_ADDR);
      rd(PERIPH_ENABLE_ADDR);
      wr(IRQ_CONTROL_ADDR0, 8'h00);
      wr(PERIPH_FLAG_ADDR, 8'h00);
      wr(PERIPH_ENABLE_ADDR, 8'h00);
      for (int k = 0; k < 3; k++) ev(k);
      rd(IRQ_CONTROL_ADDR0);
      rd(PERIPH_FLAG_ADDR);
      wr(IRQ_CONTROL_ADDR0, 8'hA0);
      ev(0);
      wr(IRQ_CONTROL_ADDR0, 8'h80);
      wr(PERIPH_ENABLE_ADDR, 8'h40);
      wr(IRQ_CONTROL_ADDR0, 8'hC0);
      wr(PERIPH_FLAG_ADDR, 8'h00);
      wr(IRQ_CONTROL_ADDR0, 8'h90);
      ev(1);
      wr(IRQ_CONTROL_ADDR0, 8'h88);
      @(posedge clk);
      pins <= 4'h4;
      pin_in <= 4'h4;
      repeat (6) @(posedge clk);
      ic[0] = 1'b1;
      rd(IRQ_CONTROL_ADDR0);
      @(posedge clk);
      pacc <= 1'b1;
      @(posedge clk);
      pacc <= 1'b0;
      repeat (4) @(posedge clk);
      wr(IRQ_CONTROL_ADDR0, 8'h88);
      @(posedge clk);
      pins <= 4'h6;
      repeat (6) @(posedge clk);
      rd(IRQ_CONTROL_ADDR0);
      pin_in <= 4'h0;
      wr(PC_HIGH_HOLDING_ADDR0, 8'hFF);
      rd(PC_HIGH_HOLDING_ADDR1);
      wr(PC_LOW_BYTE_ADDR1, 8'h34);
      chk("pc", 16'(pc), 16'(mpc));
      rd(PC_LOW_BYTE_ADDR0);
      // ten pushes so the two oldest entries are overwritten
      for (int i = 0; i < 10; i++) op((i % 3 == 2) ? 4 : 2, 11'($urandom));
      for (int i = 0; i < 10; i++) op(3, 11'h000);
      // back to back call and return restores pc
      @(posedge clk);
      ops <= 5'h04;
      tgt <= 11'($urandom);
      @(posedge clk);
      ops <= 5'h08;
      @(posedge clk);
      ops <= 5'h00;
      #1;
      chk("pc", 16'(pc), 16'(mpc));
      rd(PC_HIGH_HOLDING_ADDR0);
      wr(PC_HIGH_HOLDING_ADDR1, 8'h0F);
      op(1, 11'($urandom));
      repeat (3) op(0, 11'h000);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
